/* File: src/acs_map.vh */
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
// ==========================================================
// register offsets (byte addresses)
`define ACS_CTRL_OFF 8'h00
`define ACS_SEL_OFF 8'h04
`define ACS_RES_LO_OFF 8'h08
`define ACS_RES_HI_OFF 8'h0C
`define ACS_ACT_OFF 8'h10
// ==========================================================
// control/status field positions
`define ACS_EN_BIT 7
`define ACS_START_BIT 6
`define ACS_FREE_BIT 5
`define ACS_DONE_BIT 4
`define ACS_DIV_MSB 2
`define ACS_DIV_LSB 0
// ==========================================================
// selection field positions
`define ACS_REF_MSB 7
`define ACS_REF_LSB 6
`define ACS_CHAN_MSB 3
`define ACS_CHAN_LSB 0
// ==========================================================
// reset values
`define ACS_CTRL_RST 8'h00
`define ACS_SEL_RST 6'h00
// ==========================================================
// conversion timing in converter clock cycles
`define ACS_NORM_LEN 5'h0D
`define ACS_FIRST_LEN 5'h19
`define ACS_NORM_SH 5'h01
`define ACS_FIRST_SH 5'h0D
// cpu clock rate and converter clock limits, in kHz
`define ACS_PCLK_KHZ 50000
`define ACS_CONV_MIN_KHZ 50
`define ACS_CONV_MAX_KHZ 200
`define ACS_CPU_MIN_KHZ 100
`endif

/* File: src/acs_sequencer.v */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "acs_map.vh"

module acs_sequencer (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // analog core
    input wire [9:0] core_result,
    output wire core_power,
    output reg [3:0] core_channel,
    output reg [1:0] core_reference,
    output reg core_sample,
    output wire core_busy
);

    // ==========================================================
    // apb decode
    wire setup_ph;
    wire acc_ph;
    wire wr_en;
    wire rd_en;
    wire map_hit;
    assign setup_ph = psel & ~penable;
    assign acc_ph = psel & penable;
    assign pready = 1'b1;
    assign map_hit = (paddr == `ACS_CTRL_OFF) | (paddr == `ACS_SEL_OFF) |
                     (paddr == `ACS_RES_LO_OFF) | (paddr == `ACS_RES_HI_OFF) |
                     (paddr == `ACS_ACT_OFF);
    // unmapped addresses answer with an error
    assign pslverr = acc_ph & ~map_hit;
    assign wr_en = acc_ph & pwrite & map_hit;
    assign rd_en = acc_ph & ~pwrite;

    // ==========================================================
    // state registers
    reg en_q;              // converter enable
    reg start_q;           // start bit
    reg free_q;            // free-run select
    reg done_q;            // conversion done flag
    reg [2:0] div_q;       // divider select
    reg [3:0] hold_chan_q; // holding register, channel
    reg [1:0] hold_ref_q;  // holding register, reference
    reg [9:0] result_q;    // result bytes
    reg res_lock_q;        // result updates blocked
    reg busy_q;            // conversion running
    reg first_q;           // next conversion is extended
    reg [4:0] cyc_q;       // converter cycles since start
    reg [7:0] pre_q;       // prescaler count, reaches 255 at the largest ratio
    reg [9:0] res_s1_q;    // result synchroniser, stage one
    reg [9:0] res_s2_q;    // result synchroniser, stage two

    // ==========================================================
    // prescaler: ratio is 2 << select, 2 to 256
    wire [8:0] ratio;
    wire conv_rise;
    wire conv_fall;
    assign ratio = 9'h002 << div_q;
    // rising converter edge at the end of each period
    assign conv_rise = en_q & ({1'b0, pre_q} == ratio - 9'h001);
    // falling converter edge at mid period
    assign conv_fall = en_q & ({1'b0, pre_q} == (ratio >> 1) - 9'h001);

    // counts only while enabled, held at zero otherwise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 8'h00;
        end else if (!en_q) begin
            pre_q <= 8'h00;
        end else if (conv_rise) begin
            pre_q <= 8'h00;
        end else begin
            pre_q <= pre_q + 8'h01;
        end
    end

    // ==========================================================
    // conversion sequencing
    wire [4:0] conv_len;
    wire [4:0] sh_cyc;
    wire last_cyc;
    wire conv_end;
    wire conv_begin;
    assign conv_len = first_q ? `ACS_FIRST_LEN : `ACS_NORM_LEN;
    assign sh_cyc = first_q ? `ACS_FIRST_SH : `ACS_NORM_SH;
    assign last_cyc = busy_q & (cyc_q == conv_len - 5'h01);
    // completion on the rise that closes the last cycle
    assign conv_end = conv_rise & last_cyc;
    // idle start waits for the next converter rise
    assign conv_begin = conv_rise & ~busy_q & start_q;
    assign core_busy = busy_q;
    assign core_power = en_q;

    // busy, cycle counter and extended-conversion marker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
            cyc_q <= 5'h00;
            first_q <= 1'b1;
        end else if (!en_q) begin
            // disable aborts without completing
            busy_q <= 1'b0;
            cyc_q <= 5'h00;
            first_q <= 1'b1;
        end else if (conv_begin) begin
            busy_q <= 1'b1;
            cyc_q <= 5'h00;
        end else if (conv_end) begin
            first_q <= 1'b0;
            cyc_q <= 5'h00;
            // free-run restarts at once, ignoring the done flag
            busy_q <= free_q;
        end else if (conv_rise && busy_q) begin
            cyc_q <= cyc_q + 5'h01;
        end
    end

    // sample-and-hold pulse on the falling edge after the chosen rise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_sample <= 1'b0;
        end else begin
            core_sample <= conv_fall & busy_q & (cyc_q == sh_cyc);
        end
    end

    // ==========================================================
    // active selection: tracks holding register while enabled, except while converting before the last cycle
    wire sel_track;
    assign sel_track = ~busy_q | last_cyc;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_channel <= 4'h0;
            core_reference <= 2'h0;
        end else if (en_q && sel_track) begin
            // frozen while converting until the last cycle, so a change waits for that cycle
            core_channel <= hold_chan_q;
            core_reference <= hold_ref_q;
        end
    end

    // ==========================================================
    // result synchroniser from the analog core
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_s1_q <= 10'h000;
            res_s2_q <= 10'h000;
        end else begin
            res_s1_q <= core_result;
            res_s2_q <= res_s1_q;
        end
    end

    // ==========================================================
    // software-visible control bits
    wire ctrl_wr;
    wire sel_wr;
    wire lo_rd;
    wire hi_rd;
    assign ctrl_wr = wr_en & (paddr == `ACS_CTRL_OFF);
    assign sel_wr = wr_en & (paddr == `ACS_SEL_OFF);
    assign lo_rd = rd_en & (paddr == `ACS_RES_LO_OFF);
    assign hi_rd = rd_en & (paddr == `ACS_RES_HI_OFF);

    // enable, free-run and divider select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 1'b0;
            free_q <= 1'b0;
            div_q <= 3'h0;
        end else if (ctrl_wr) begin
            en_q <= pwdata[`ACS_EN_BIT];
            free_q <= pwdata[`ACS_FREE_BIT];
            div_q <= pwdata[`ACS_DIV_MSB:`ACS_DIV_LSB];
        end
    end

    // start bit: written one together with enable sets, hardware clears at single end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_q <= 1'b0;
        end else if (ctrl_wr && pwdata[`ACS_START_BIT] && pwdata[`ACS_EN_BIT]) begin
            // a write that enables and starts at once must not lose the start
            start_q <= 1'b1;
        end else if (!en_q) begin
            start_q <= 1'b0;
        end else if (conv_end && !free_q) begin
            start_q <= 1'b0;
        end
    end

    // done flag: set wins over a write-one clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (conv_end) begin
            done_q <= 1'b1;
        end else if (ctrl_wr && pwdata[`ACS_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // holding register for channel and reference
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_chan_q <= 4'h0;
            hold_ref_q <= 2'h0;
        end else if (sel_wr) begin
            hold_chan_q <= pwdata[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
            hold_ref_q <= pwdata[`ACS_REF_MSB:`ACS_REF_LSB];
        end
    end

    // ==========================================================
    // result registers and low-then-high read lock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 10'h000;
            res_lock_q <= 1'b0;
        end else begin
            if (conv_end && !res_lock_q) begin
                result_q <= res_s2_q;
            end
            if (hi_rd) begin
                res_lock_q <= 1'b0;
            end else if (lo_rd) begin
                res_lock_q <= 1'b1;
            end
        end
    end

    // ==========================================================
    // read data, captured in the setup cycle
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h00000000;
        case (paddr)
            `ACS_CTRL_OFF: begin
                rd_d[`ACS_EN_BIT] = en_q;
                rd_d[`ACS_START_BIT] = start_q;
                rd_d[`ACS_FREE_BIT] = free_q;
                rd_d[`ACS_DONE_BIT] = done_q;
                rd_d[`ACS_DIV_MSB:`ACS_DIV_LSB] = div_q;
            end
            `ACS_SEL_OFF: begin
                rd_d[`ACS_REF_MSB:`ACS_REF_LSB] = hold_ref_q;
                rd_d[`ACS_CHAN_MSB:`ACS_CHAN_LSB] = hold_chan_q;
            end
            `ACS_RES_LO_OFF: begin
                rd_d[7:0] = result_q[7:0];
            end
            `ACS_RES_HI_OFF: begin
                rd_d[1:0] = result_q[9:8];
            end
            `ACS_ACT_OFF: begin
                rd_d[`ACS_REF_MSB:`ACS_REF_LSB] = core_reference;
                rd_d[`ACS_CHAN_MSB:`ACS_CHAN_LSB] = core_channel;
                rd_d[8] = busy_q;
                rd_d[9] = first_q;
                rd_d[10] = res_lock_q;
            end
            default: begin
                rd_d = 32'h00000000;
            end
        endcase
    end

    // register the read word so the access phase returns a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup_ph && !pwrite) begin
            prdata <= rd_d;
        end
    end

endmodule // acs_sequencer

/* File: test/acs_core_model.sv */
`timescale 1ns/100ps
module acs_core_model (
    // sequencer side
    input wire pclk,
    input wire presetn,
    input wire core_power,
    input wire [3:0] core_channel,
    input wire [1:0] core_reference,
    input wire core_sample,
    // result back
    output wire [9:0] core_result
);
    logic [9:0] held_q; // selection and count latched at the hold instant
    // hold stage: capture what was selected when the pulse came
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            held_q <= 10'h000;
        else if (core_sample)
            held_q <= {core_reference, core_channel, held_q[3:0] + 4'h1};
    end
    // a core without power gives the complement of the held value
    assign core_result = core_power ? held_q : ~held_q;
endmodule // acs_core_model

/* File: test/acs_sequencer_assertions.sv */
`timescale 1ns/100ps
module acs_sequencer_assertions (
    // apb side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    // core side
    input wire core_power,
    input wire [3:0] core_channel,
    input wire core_sample,
    input wire core_busy
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ====================
    // helper: channel written while idle
    wire sel_wr = psel && penable && pwrite && paddr == 8'h04 && core_power && !core_busy;
    logic [3:0] wr_q; // last idle channel write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wr_q <= 4'h0;
        else if (sel_wr)
            wr_q <= pwdata[3:0];
    end
    sequence frozen_s;
        $stable(core_channel) ##1 $stable(core_channel);
    endsequence
    // ====================
    // properties
    chk_sample_busy: assert property (core_sample |-> core_busy)
        else $error("hold pulse outside conversion");
    chk_sample_pulse: assert property (core_sample |=> !core_sample)
        else $error("hold pulse too long");
    chk_off_idle: assert property (!core_power [*2] |-> !core_busy)
        else $error("busy while disabled");
    chk_off_quiet: assert property (!core_power [*2] |-> !core_sample)
        else $error("hold pulse while disabled");
    chk_change_gap: assert property ($changed(core_channel) |-> !core_sample [*3])
        else $error("hold too soon after channel change");
    chk_hold_frozen: assert property (core_sample |-> frozen_s)
        else $error("channel moved around hold");
    chk_sel_track: assert property (sel_wr |-> ##[1:2] core_channel == wr_q)
        else $error("idle channel not tracking");
    chk_err_unmapped: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
        else $error("no error on unmapped access");
    chk_err_data: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("data on refused read");
endmodule // acs_sequencer_assertions
bind acs_sequencer acs_sequencer_assertions acs_sequencer_assertions_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .core_power(core_power),
    .core_channel(core_channel), .core_sample(core_sample), .core_busy(core_busy));

/* File: test/acs_sequencer_bench.sv */
`timescale 1ns/100ps
module acs_sequencer_bench;
    // ====================
    // signals
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, core_power, core_sample, core_busy;
    wire [3:0] core_channel;
    wire [1:0] core_reference;
    wire [9:0] core_result;
    int error_cnt = 0;
    int tests_run = 0;
    int n, smp_n = 0, blen = 0, last_len = 0, s0 = 0;
    logic [31:0] rd;
    logic err;
    logic [2:0] dv;
    logic [3:0] ch;
    logic [1:0] rf;
    always #10 pclk = ~pclk;
    acs_sequencer acs_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .core_result(core_result),
        .core_power(core_power), .core_channel(core_channel),
        .core_reference(core_reference), .core_sample(core_sample), .core_busy(core_busy));
    acs_core_model acs_core_model_i (.pclk(pclk), .presetn(presetn),
        .core_power(core_power), .core_channel(core_channel),
        .core_reference(core_reference), .core_sample(core_sample),
        .core_result(core_result));
    // length of last conversion and count of hold pulses
    always @(posedge pclk) begin
        smp_n <= smp_n + core_sample;
        if (core_busy === 1'b1)
            blen <= blen + 1;
        else if (blen != 0) begin
            last_len <= blen;
            blen <= 0;
        end
    end
    // ====================
    // helpers
    function int rt(input logic [2:0] d);
        return 2 << d;
    endfunction
    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task bound(input int lim);
        if (n >= lim) begin
            error_cnt++;
            $display("[FAIL] wait expected end seen timeout");
            wrap_up();
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        bound(50);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task go(input logic [7:0] ctl);
        apb(1, 8'h00, {24'h0, ctl});
        for (n = 0; core_busy !== 1'b1 && n < 1000; n++)
            @(posedge pclk);
        bound(1000);
    endtask
    task idle;
        for (n = 0; core_busy !== 1'b0 && n < 20000; n++)
            @(posedge pclk);
        bound(20000);
        repeat (2) @(posedge pclk);
    endtask
    task sel(input logic [3:0] c, input logic [1:0] r);
        apb(1, 8'h04, {24'h0, r, 2'b00, c});
    endtask
    task res(input logic [3:0] c, input logic [1:0] r);
        apb(0, 8'h08, 0);
        check("result channel", c, rd[7:4]);
        apb(0, 8'h0C, 0);
        check("result reference", r, rd[1:0]);
    endtask
    // ====================
    // main sequence
    initial begin
        void'($urandom(50444));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        dv = $urandom_range(2, 0);
        ch = $urandom;
        rf = $urandom;
        apb(0, 8'h00, 0);
        check("ctrl reset", 0, rd);
        apb(0, 8'h14, 0);
        check("unmapped error", 1, err);
        check("unmapped data", 0, rd);
        sel(ch, rf);
        go(8'hC0 | dv);
        idle();
        apb(0, 8'h00, 0);
        check("ctrl after end", {4'h9, 1'b0, dv}, rd[7:0]);
        check("first length", 25 * rt(dv), last_len);
        res(ch, rf);
        $display("test single done");
        go(8'hD0 | dv);
        sel(~ch, rf);
        idle();
        check("normal length", 13 * rt(dv), last_len);
        res(ch, rf);
        go(8'hD0 | dv);
        idle();
        res(~ch, rf);
        sel(ch, rf);
        apb(0, 8'h08, 0);
        go(8'hD0 | dv);
        idle();
        apb(0, 8'h00, 0);
        check("done while locked", 1, rd[4]);
        res(~ch, rf);
        go(8'hD0 | dv);
        idle();
        res(ch, rf);
        $display("test selection done");
        apb(1, 8'h00, {24'h0, 8'hB0 | dv});
        repeat (600) @(posedge pclk);
        check("free without start", 0, core_busy);
        s0 = smp_n;
        go(8'hE0 | dv);
        repeat (52 * rt(dv)) @(posedge pclk);
        check("free samples", 1, smp_n - s0 >= 3);
        apb(0, 8'h00, 0);
        check("free start held", 1, rd[6]);
        apb(1, 8'h00, {24'h0, 8'h90 | dv});
        idle();
        apb(0, 8'h00, 0);
        check("free stop", 0, rd[6]);
        $display("test free run done");
        go(8'hD0 | dv);
        apb(1, 8'h00, 0);
        apb(0, 8'h00, 0);
        check("abort ctrl", 0, rd);
        check("abort power", 0, core_power);
        for (int d = 0; d < 8; d++) begin
            go({5'b11010, d[2:0]});
            idle();
            check("extended length", 25 * rt(d[2:0]), last_len);
            apb(1, 8'h00, 0);
        end
        $display("test abort and divider done");
        wrap_up();
    end
endmodule // acs_sequencer_bench
